// ==== hw/srwp_top.sv ====
// Top of the strap, reset, wake and shared pin block
module srwp_top
   import srwp_pkg::*;
(
   input wire logic REF_CLK_I,
   input wire logic RESET_N_I,
   input wire logic POR_N_I,
   input wire logic SPEED_STRAP_I,
   input wire logic CHIP_SELECT_LOW_I,
   input wire logic WRITE_STROBE_LOW_I,
   input wire logic READ_STROBE_LOW_I,
   input wire srwp_pkg::srwp_data_mode_t DATA_MODE_I,
   input wire srwp_pkg::srwp_clk_mode_t CLK_MODE_I,
   input wire logic GENERAL_OUTPUT_THREE_I,
   input wire logic GENERAL_OUTPUT_FOUR_I,
   input wire logic EE_SELECT_I,
   input wire logic EE_CLOCK_I,
   input wire logic EE_DOUT_I,
   input wire logic EE_DOE_I,
   input wire logic EEPROM_DATA_IO_I,
   input wire logic MII_TX_EN_I,
   input wire logic MII_TX_CLK_I,
   input wire logic MII_RX_DV_I,
   input wire logic MII_RX_CLK_I,
   input wire logic WAKE_ENABLE_I,
   input wire logic WAKE_POLARITY_I,
   input wire logic WAKE_OPEN_DRAIN_I,
   input wire logic WAKE_EVENT_I,
   input wire logic WAKE_CLEAR_I,
   input wire logic SLEEP_REQ_I,
   output logic RESET_N_O,
   output logic SPEED_100_O,
   output logic FULL_DUPLEX_O,
   output logic AUTONEG_EN_O,
   output logic EEPROM_DATA_IO_O,
   output logic EEPROM_DATA_IO_OE_O,
   output logic EEPROM_DATA_IN_O,
   output logic EEPROM_SERIAL_CLOCK_O,
   output logic EEPROM_SELECT_O,
   output logic WAKE_INDICATOR_O,
   output logic WAKE_INDICATOR_OE_O,
   output logic POWER_SAVE_O,
   output logic WRITE_ENABLED_O,
   output logic WRITE_ACCEPT_O
);
   import srwp_pkg::*;
   logic rst_n;
   logic strap;
   logic strap_taken;
   logic wake_pending;
   logic power_save;
   logic read_seen;
   logic cs_wr_d;
   logic cs_rd_d;
   logic host_wr;
   logic host_rd;
   logic wr_start;
   logic rd_start;
   logic wake_level;

   srwp_por #(
      .CYCLES(SRWP_POR_CYCLES)
   ) u_por (
      .clk_i(REF_CLK_I),
      .ext_reset_n_i(RESET_N_I),
      .por_n_i(POR_N_I),
      .rst_n_o(rst_n)
   );

   // Strap is caught by a clocked process on the first cycle out of reset
   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         strap <= SRWP_STRAP_RESET;
         strap_taken <= 1'b0;
      end else if (!strap_taken) begin
         strap <= SPEED_STRAP_I;
         strap_taken <= 1'b1;
      end
   end

   assign host_wr = !CHIP_SELECT_LOW_I && !WRITE_STROBE_LOW_I;
   assign host_rd = !CHIP_SELECT_LOW_I && !READ_STROBE_LOW_I;

   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         cs_wr_d <= 1'b0;
         cs_rd_d <= 1'b0;
      end else begin
         cs_wr_d <= host_wr;
         cs_rd_d <= host_rd;
      end
   end
   assign wr_start = host_wr && !cs_wr_d;
   assign rd_start = host_rd && !cs_rd_d;

   // Power saving ends on any write cycle, data ignored
   // Level, not edge: a write already under way at sleep entry still wakes
   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         power_save <= 1'b0;
      end else if (power_save && host_wr) begin
         power_save <= 1'b0;
      end else if (SLEEP_REQ_I && !power_save) begin
         power_save <= 1'b1;
      end
   end

   // Writes are dead until a read after reset or after leaving power saving
   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         read_seen <= 1'b0;
      end else if (rd_start && !power_save) begin
         read_seen <= 1'b1;
      end else if (power_save) begin
         read_seen <= 1'b0;
      end
   end

   // Event wins over clear in the same cycle
   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         wake_pending <= 1'b0;
      end else if (WAKE_EVENT_I && WAKE_ENABLE_I) begin
         wake_pending <= 1'b1;
      end else if (WAKE_CLEAR_I) begin
         wake_pending <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         wake_level <= 1'b0;
      end else begin
         wake_level <= wake_pending ^ !WAKE_POLARITY_I;
      end
   end

   srwp_pinmux u_pinmux (
      .data_mode_i(DATA_MODE_I),
      .clk_mode_i(CLK_MODE_I),
      .ee_select_i(EE_SELECT_I),
      .ee_clock_i(EE_CLOCK_I),
      .ee_dout_i(EE_DOUT_I),
      .ee_doe_i(EE_DOE_I),
      .gen_out_three_i(GENERAL_OUTPUT_THREE_I),
      .gen_out_four_i(GENERAL_OUTPUT_FOUR_I),
      .tx_en_i(MII_TX_EN_I),
      .tx_clk_i(MII_TX_CLK_I),
      .rx_dv_i(MII_RX_DV_I),
      .rx_clk_i(MII_RX_CLK_I),
      .data_o(EEPROM_DATA_IO_O),
      .data_oe_o(EEPROM_DATA_IO_OE_O),
      .clock_o(EEPROM_SERIAL_CLOCK_O),
      .select_o(EEPROM_SELECT_O)
   );

   // Input path exists only in the EEPROM role
   assign EEPROM_DATA_IN_O = (DATA_MODE_I == SRWP_DATA_EEPROM) ?
      EEPROM_DATA_IO_I : 1'b0;
   assign RESET_N_O = rst_n;
   assign SPEED_100_O = strap;
   assign FULL_DUPLEX_O = 1'b0;
   assign AUTONEG_EN_O = (strap == SRWP_SPEED_100);
   // Open drain drives only the low level, whatever the polarity
   assign WAKE_INDICATOR_O = wake_level;
   // Driver off until the level flop holds a polarity-correct value,
   // else an active-low indicator would pulse right after reset
   assign WAKE_INDICATOR_OE_O = strap_taken &&
      (!WAKE_OPEN_DRAIN_I || !wake_level);
   assign POWER_SAVE_O = power_save;
   assign WRITE_ENABLED_O = read_seen;
   assign WRITE_ACCEPT_O = wr_start && read_seen && !power_save;
endmodule

// ==== hw/srwp_pkg.sv ====
// Package of constants and types for the strap, reset, wake and pin block
// Summary of operation
// - Strap low: 10 Mb/s half, no autoneg; high: 100 Mb/s half, autoneg on.
// - Strap level is captured at reset release and held as default settings.
// - EEPROM data pin may be general output three or TX_EN/TX_CLK monitor.
// - In those data pin roles the EEPROM select stays deasserted.
// - EEPROM clock pin may be general output four or RX_DV/RX_CLK monitor.
// - In those clock pin roles the EEPROM select stays deasserted.
// - General outputs three and four have no input path.
// - External reset low resets all logic and registers.
// - Without external reset, internal power-on reset initialises the part.
// - After reset or wake, writes are ignored until one host read occurs.
// - When enabled, a wake event asserts the wake indicator.
// - Wake indicator polarity and driver type are programmable.
// - Wake events do not end power saving; only a host write cycle does.
// - Any host write in power saving wakes the device, whatever its data.
package srwp_pkg;
   typedef enum logic [1:0] {
      SRWP_DATA_EEPROM,
      SRWP_DATA_GPO,
      SRWP_DATA_TXEN,
      SRWP_DATA_TXCLK
   } srwp_data_mode_t;
   typedef enum logic [1:0] {
      SRWP_CLK_EEPROM,
      SRWP_CLK_GPO,
      SRWP_CLK_RXDV,
      SRWP_CLK_RXCLK
   } srwp_clk_mode_t;
   localparam logic SRWP_SPEED_10 = 1'b0;
   localparam logic SRWP_SPEED_100 = 1'b1;
   localparam logic SRWP_STRAP_RESET = 1'b0;
   localparam int SRWP_POR_CYCLES = 16;
   localparam logic [4:0] SRWP_POR_CNT_W = 5'h05;
endpackage

// ==== hw/srwp_por.sv ====
// Internal power-on reset generator merged with the external reset
module srwp_por
   import srwp_pkg::*;
#(
   parameter int CYCLES = SRWP_POR_CYCLES
) (
   input wire logic clk_i,
   input wire logic ext_reset_n_i,
   input wire logic por_n_i,
   output logic rst_n_o
);
   logic [7:0] count;
   logic done;
   wire logic any_n = ext_reset_n_i & por_n_i;
   // Stretch so reset releases cleanly on a clock edge
   always_ff @(posedge clk_i or negedge any_n) begin
      if (!any_n) begin
         count <= 8'h00;
         done <= 1'b0;
      end else if (!done) begin
         count <= count + 8'h01;
         done <= (count == 8'(CYCLES - 1));
      end
   end
   assign rst_n_o = done;
endmodule

// ==== hw/srwp_pinmux.sv ====
// Multiplexer for the two shared EEPROM pins
module srwp_pinmux
   import srwp_pkg::*;
(
   input wire srwp_data_mode_t data_mode_i,
   input wire srwp_clk_mode_t clk_mode_i,
   input wire logic ee_select_i,
   input wire logic ee_clock_i,
   input wire logic ee_dout_i,
   input wire logic ee_doe_i,
   input wire logic gen_out_three_i,
   input wire logic gen_out_four_i,
   input wire logic tx_en_i,
   input wire logic tx_clk_i,
   input wire logic rx_dv_i,
   input wire logic rx_clk_i,
   output logic data_o,
   output logic data_oe_o,
   output logic clock_o,
   output logic select_o
);
   always_comb begin
      case (data_mode_i)
         SRWP_DATA_GPO: data_o = gen_out_three_i;
         SRWP_DATA_TXEN: data_o = tx_en_i;
         SRWP_DATA_TXCLK: data_o = tx_clk_i;
         default: data_o = ee_dout_i;
      endcase
      // Non-EEPROM roles always drive; no input path there
      data_oe_o = (data_mode_i == SRWP_DATA_EEPROM) ? ee_doe_i : 1'b1;
      case (clk_mode_i)
         SRWP_CLK_GPO: clock_o = gen_out_four_i;
         SRWP_CLK_RXDV: clock_o = rx_dv_i;
         SRWP_CLK_RXCLK: clock_o = rx_clk_i;
         default: clock_o = ee_clock_i;
      endcase
      // Guard against stray EEPROM accesses
      select_o = ee_select_i && (data_mode_i == SRWP_DATA_EEPROM) &&
         (clk_mode_i == SRWP_CLK_EEPROM);
   end
endmodule

// ==== verif/srwp_host_model.sv ====
// Behavioural host issuing strobed bus cycles
module srwp_host_model (
   input wire logic REF_CLK_I,
   input wire logic WRITE_ACCEPT_O,
   output logic CHIP_SELECT_LOW_I,
   output logic WRITE_STROBE_LOW_I,
   output logic READ_STROBE_LOW_I
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      CHIP_SELECT_LOW_I = 1'b1;
      WRITE_STROBE_LOW_I = 1'b1;
      READ_STROBE_LOW_I = 1'b1;
   end
   // No address port, so the waking write has no target here
   task automatic access(input logic wr, output logic acc);
      @(posedge REF_CLK_I);
      CHIP_SELECT_LOW_I <= 1'b0;
      WRITE_STROBE_LOW_I <= !wr;
      READ_STROBE_LOW_I <= wr;
      @(negedge REF_CLK_I);
      acc = WRITE_ACCEPT_O;
      @(posedge REF_CLK_I);
      CHIP_SELECT_LOW_I <= 1'b1;
      WRITE_STROBE_LOW_I <= 1'b1;
      READ_STROBE_LOW_I <= 1'b1;
   endtask
endmodule

// ==== verif/srwp_sva.sv ====
// Port assertions for the strap, reset, wake and pin block
module srwp_chk
   import srwp_pkg::*;
(
   input wire logic REF_CLK_I,
   input wire logic RESET_N_I,
   input wire logic CHIP_SELECT_LOW_I,
   input wire logic WRITE_STROBE_LOW_I,
   input wire srwp_pkg::srwp_data_mode_t DATA_MODE_I,
   input wire srwp_pkg::srwp_clk_mode_t CLK_MODE_I,
   input wire logic WAKE_ENABLE_I,
   input wire logic WAKE_EVENT_I,
   input wire logic WAKE_POLARITY_I,
   input wire logic RESET_N_O,
   input wire logic SPEED_100_O,
   input wire logic AUTONEG_EN_O,
   input wire logic EEPROM_SELECT_O,
   input wire logic WAKE_INDICATOR_O,
   input wire logic POWER_SAVE_O,
   input wire logic WRITE_ENABLED_O,
   input wire logic WRITE_ACCEPT_O
);
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (!RESET_N_O);
   sequence wr_s;
      !CHIP_SELECT_LOW_I && !WRITE_STROBE_LOW_I;
   endsequence
   reset_src_a: assert property (
      RESET_N_O |-> $past(RESET_N_I)) else $error("reset");
   strap_keep_a: assert property (
      $past(RESET_N_O, 2) |-> $stable(SPEED_100_O)) else $error("strap");
   cfg_pair_a: assert property (
      AUTONEG_EN_O == SPEED_100_O) else $error("cfg");
   sel_off_a: assert property (
      DATA_MODE_I != SRWP_DATA_EEPROM |-> !EEPROM_SELECT_O) else $error("sel");
   clk_sel_off_a: assert property (
      CLK_MODE_I != SRWP_CLK_EEPROM |-> !EEPROM_SELECT_O) else $error("csel");
   write_gate_a: assert property (
      WRITE_ACCEPT_O |-> wr_s ##0 (WRITE_ENABLED_O && !POWER_SAVE_O))
      else $error("gate");
   write_wake_a: assert property (
      POWER_SAVE_O ##0 wr_s |=> !POWER_SAVE_O && !WRITE_ENABLED_O)
      else $error("wake");
   sleep_hold_a: assert property (
      POWER_SAVE_O && CHIP_SELECT_LOW_I |=> POWER_SAVE_O) else $error("hold");
   wake_out_a: assert property (
      WAKE_EVENT_I && WAKE_ENABLE_I |->
         ##2 WAKE_INDICATOR_O == WAKE_POLARITY_I)
      else $error("ind");
endmodule
bind srwp_top srwp_chk i_chk (.*);

// ==== verif/strap_reset_wake_pin_control_test.sv ====
// Self-checking bench for the strap, reset, wake and pin block
module strap_reset_wake_pin_control_test
   import srwp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic REF_CLK_I, RESET_N_I, POR_N_I, SPEED_STRAP_I, SLEEP_REQ_I;
   logic CHIP_SELECT_LOW_I, WRITE_STROBE_LOW_I, READ_STROBE_LOW_I;
   srwp_data_mode_t DATA_MODE_I;
   srwp_clk_mode_t CLK_MODE_I;
   logic GENERAL_OUTPUT_THREE_I, GENERAL_OUTPUT_FOUR_I, EE_SELECT_I;
   logic EE_CLOCK_I, EE_DOUT_I, EE_DOE_I, EEPROM_DATA_IO_I, MII_TX_EN_I;
   logic MII_TX_CLK_I, MII_RX_DV_I, MII_RX_CLK_I, WAKE_ENABLE_I;
   logic WAKE_POLARITY_I, WAKE_OPEN_DRAIN_I, WAKE_EVENT_I, WAKE_CLEAR_I;
   logic RESET_N_O, SPEED_100_O, FULL_DUPLEX_O, AUTONEG_EN_O;
   logic EEPROM_DATA_IO_O, EEPROM_DATA_IO_OE_O, EEPROM_DATA_IN_O;
   logic EEPROM_SERIAL_CLOCK_O, EEPROM_SELECT_O, WAKE_INDICATOR_O;
   logic WAKE_INDICATOR_OE_O, POWER_SAVE_O, WRITE_ENABLED_O, WRITE_ACCEPT_O;
   logic [10:0] pv;
   logic [31:0] seed = 32'h55430443;
   int miscompares = 0;
   int checked = 0;
   assign {GENERAL_OUTPUT_THREE_I, GENERAL_OUTPUT_FOUR_I, EE_SELECT_I,
      EE_CLOCK_I, EE_DOUT_I, EE_DOE_I, EEPROM_DATA_IO_I, MII_TX_EN_I,
      MII_TX_CLK_I, MII_RX_DV_I, MII_RX_CLK_I} = pv;
   srwp_top i_dut (.*);
   srwp_host_model i_host (.*);
   function automatic logic [10:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[10:0];
   endfunction
   function automatic logic [4:0] mux_exp();
      logic [3:0] dv;
      logic [3:0] cv;
      logic ee;
      dv = {MII_TX_CLK_I, MII_TX_EN_I, GENERAL_OUTPUT_THREE_I, EE_DOUT_I};
      cv = {MII_RX_CLK_I, MII_RX_DV_I, GENERAL_OUTPUT_FOUR_I, EE_CLOCK_I};
      ee = DATA_MODE_I == SRWP_DATA_EEPROM;
      return {dv[DATA_MODE_I], cv[CLK_MODE_I], ee ? EE_DOE_I : 1'b1,
         EE_SELECT_I && ee && CLK_MODE_I == SRWP_CLK_EEPROM,
         ee && EEPROM_DATA_IO_I};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      REF_CLK_I = 1'b0;
      forever #4 REF_CLK_I = !REF_CLK_I;
   end
   initial begin
      #50us;
      miscompares++;
      wrap_up();
   end
   initial begin
      logic a;
      logic lvl;
      logic [10:0] t;
      int p;
      {RESET_N_I, SPEED_STRAP_I, SLEEP_REQ_I, WAKE_EVENT_I} = '0;
      {WAKE_CLEAR_I, WAKE_POLARITY_I, WAKE_OPEN_DRAIN_I, pv} = '0;
      {POR_N_I, WAKE_ENABLE_I} = 2'h3;
      DATA_MODE_I = SRWP_DATA_EEPROM;
      CLK_MODE_I = SRWP_CLK_EEPROM;
      for (int r = 0; r < 2; r++) begin
         @(posedge REF_CLK_I);
         SPEED_STRAP_I <= r[0];
         RESET_N_I <= r[0];
         POR_N_I <= !r[0];
         repeat (10) @(posedge REF_CLK_I);
         {RESET_N_I, POR_N_I} <= 2'h3;
         for (p = 0; p < 40 && RESET_N_O !== 1'b1; p++) @(posedge REF_CLK_I);
         repeat (2) @(posedge REF_CLK_I);
         SPEED_STRAP_I <= !r[0];
         repeat (3) @(negedge REF_CLK_I);
         check({RESET_N_O, SPEED_100_O, AUTONEG_EN_O, FULL_DUPLEX_O,
            POWER_SAVE_O, WRITE_ENABLED_O},
            {1'b1, r[0], r[0], 3'h0});
         for (int i = 0; i < 64; i++) begin
            @(posedge REF_CLK_I);
            DATA_MODE_I <= srwp_data_mode_t'(i[1:0]);
            CLK_MODE_I <= srwp_clk_mode_t'(i[3:2]);
            pv <= rnd();
            @(negedge REF_CLK_I);
            check({EEPROM_DATA_IO_O, EEPROM_SERIAL_CLOCK_O,
               EEPROM_DATA_IO_OE_O, EEPROM_SELECT_O, EEPROM_DATA_IN_O},
               mux_exp());
         end
         t = rnd();
         lvl = !(t[1] ^ r[0]);
         @(posedge REF_CLK_I);
         // First pass keeps the event masked
         {WAKE_ENABLE_I, WAKE_POLARITY_I, WAKE_OPEN_DRAIN_I} <= {r[0], t[1:0]};
         i_host.access(1'b1, a);
         check(a, 8'h00);
         i_host.access(1'b0, a);
         i_host.access(1'b1, a);
         check(a, 8'h01);
         SLEEP_REQ_I <= 1'b1;
         for (p = 0; p < 20 && POWER_SAVE_O !== 1'b1; p++) @(posedge REF_CLK_I);
         {SLEEP_REQ_I, WAKE_EVENT_I} <= 2'h1;
         @(posedge REF_CLK_I);
         WAKE_EVENT_I <= 1'b0;
         repeat (4) @(negedge REF_CLK_I);
         check({POWER_SAVE_O, WAKE_INDICATOR_O, WAKE_INDICATOR_OE_O},
            {1'b1, lvl, !(t[0] && lvl)});
         i_host.access(1'b1, a);
         @(negedge REF_CLK_I);
         check({a, POWER_SAVE_O, WRITE_ENABLED_O}, 8'h00);
         i_host.access(1'b1, a);
         check(a, 8'h00);
         i_host.access(1'b0, a);
         i_host.access(1'b1, a);
         check(a, 8'h01);
         WAKE_CLEAR_I <= 1'b1;
         @(posedge REF_CLK_I);
         WAKE_CLEAR_I <= 1'b0;
         repeat (3) @(negedge REF_CLK_I);
         check(WAKE_INDICATOR_O, !t[1]);
         $display("pass %0d done", r);
      end
      wrap_up();
   end
endmodule
